// *** hw/txpg_pkg.sv ***
// Purpose: Shared constants for the transmit packet gap adapter
// Assumes: One clock for offload engine side, buffer and MAC side
// Notes:   FIFO word = {spare, last, first, empty[1:0], data[63:0]}
package txpg_pkg;
  // ****************************************************************
  // Buffer geometry
  // ****************************************************************
  localparam int FIFO_DEPTH  = 2048;
  localparam int CNT_W       = 12;
  localparam int DATA_W      = 64;
  localparam int IEMP_W      = 2;
  localparam int EEMP_W      = 3;
  localparam int WORD_W      = 69;
  localparam int OUT_W       = DATA_W + EEMP_W + 2;
  // ****************************************************************
  // Word fields
  // ****************************************************************
  localparam int F_DATA_LSB  = 0;
  localparam int F_EMP_LSB   = 64;
  localparam int F_FIRST     = 66;
  localparam int F_LAST      = 67;
  localparam int F_SPARE     = 68;
  // ****************************************************************
  // Flow thresholds
  // ****************************************************************
  localparam logic [CNT_W-1:0] FILL_LIMIT = 12'h300;
  localparam int START_LSB   = 2;
  localparam int START_MSB   = 10;
  localparam logic [0:0] SPARE_VAL = 1'h0;
endpackage : txpg_pkg

// *** hw/txpg_fifo_if.sv ***
// Purpose: Carrier between adapter control and its packet FIFO
// Assumes: Same clock on both sides
// Notes:   Read side is show-ahead
`timescale 1ns/1ns
interface txpg_fifo_if;
  logic                           wr_strobe;
  logic [txpg_pkg::WORD_W-1:0]    wr_word;
  logic                           rd_ack;
  logic [txpg_pkg::WORD_W-1:0]    rd_word;
  logic [txpg_pkg::CNT_W-1:0]     fill_count;
  logic                           empty;
  modport ctrl (output wr_strobe, output wr_word, output rd_ack,
                input rd_word, input fill_count, input empty);
  modport store (input wr_strobe, input wr_word, input rd_ack,
                 output rd_word, output fill_count, output empty);
endinterface : txpg_fifo_if

// *** hw/txpg_sa_fifo.sv ***
// Purpose: Show-ahead packet FIFO with fill count
// Assumes: Writer never pushes into a full buffer
// Notes:   Head word is readable before the acknowledge
`timescale 1ns/1ns
module txpg_sa_fifo #(
  parameter int DEPTH = txpg_pkg::FIFO_DEPTH
) (
  input  logic      clk_i,
  input  logic      sys_rst_i,
  txpg_fifo_if.store fif
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH != (1 << AW) || DEPTH >= (1 << txpg_pkg::CNT_W)) begin : g_chk
    $error("txpg_sa_fifo: DEPTH must be a power of two below count range");
  end
  typedef struct packed {
    logic [AW-1:0]              wr_ptr;
    logic [AW-1:0]              rd_ptr;
    logic [txpg_pkg::CNT_W-1:0] count;
  } txpg_fifo_st_t;
  txpg_fifo_st_t s_q, s_d;
  logic [txpg_pkg::WORD_W-1:0] mem_q [DEPTH];
  logic push, pop;
  localparam logic [txpg_pkg::CNT_W-1:0] FULL_CNT = txpg_pkg::CNT_W'(DEPTH);
  assign push = fif.wr_strobe && (s_q.count != FULL_CNT);
  assign pop  = fif.rd_ack && (s_q.count != '0);
  assign fif.rd_word    = mem_q[s_q.rd_ptr]; // R2
  assign fif.fill_count = s_q.count;
  assign fif.empty      = (s_q.count == '0);
  always_comb begin
    s_d = s_q;
    if (push) s_d.wr_ptr = s_q.wr_ptr + AW'(1);
    if (pop)  s_d.rd_ptr = s_q.rd_ptr + AW'(1);
    if (push && !pop) s_d.count = s_q.count + txpg_pkg::CNT_W'(1);
    if (pop && !push) s_d.count = s_q.count - txpg_pkg::CNT_W'(1);
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) s_q <= '0; // R15
    else           s_q <= s_d;
  end
  always_ff @(posedge clk_i) begin
    if (push) mem_q[s_q.wr_ptr] <= fif.wr_word; // R1
  end
  a_depth_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
    s_q.count <= FULL_CNT) else $error("fill count above depth");
  a_show_ahead: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
    (push && s_q.count == '0) |=> (fif.rd_word == $past(fif.wr_word)))
    else $error("head word not shown after write to empty buffer");
endmodule : txpg_sa_fifo

// *** hw/txpg_skid2.sv ***
// Purpose: Two-entry buffer feeding the MAC stream outputs
// Assumes: Source honours in_ready
// Notes:   Output valid and data come straight from flops
`timescale 1ns/1ns
module txpg_skid2 #(
  parameter int W = txpg_pkg::OUT_W
) (
  input  logic         clk_i,
  input  logic         sys_rst_i,
  input  logic         in_valid_i,
  input  logic [W-1:0] in_data_i,
  output logic         in_ready_o,
  output logic         out_valid_o,
  output logic [W-1:0] out_data_o,
  input  logic         out_ready_i
);
  if (W < 1) begin : g_chk
    $error("txpg_skid2: W must be positive");
  end
  typedef struct packed {
    logic         v0;
    logic         v1;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
  } txpg_skid_st_t;
  txpg_skid_st_t s_q, s_d;
  logic pop, push;
  assign pop        = s_q.v0 && out_ready_i;
  assign push       = in_valid_i && !s_q.v1;
  assign in_ready_o = !s_q.v1;
  assign out_valid_o = s_q.v0;
  assign out_data_o  = s_q.d0;
  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.v0 = s_q.v1;
      s_d.d0 = s_q.d1;
      s_d.v1 = 1'b0;
    end
    if (push) begin
      if (!s_d.v0) begin
        s_d.v0 = 1'b1;
        s_d.d0 = in_data_i;
      end else begin
        s_d.v1 = 1'b1;
        s_d.d1 = in_data_i;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) s_q <= '0; // R15
    else           s_q <= s_d;
  end
  a_hold_stall: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o)))
    else $error("stream output changed during stall");
  a_no_loss: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
    (s_q.v0 && s_q.v1 && !out_ready_i) |=> (s_q.v0 && s_q.v1 && $stable(s_q.d1)))
    else $error("buffered word lost during stall");
endmodule : txpg_skid2

// *** hw/txpg_tx_packet_adapter.sv ***
// Purpose: Transmit adapter from gapless packet source to stallable MAC stream
// Assumes: Source, buffer and MAC stream share clk_i
// Notes:   Egress outputs are the output stage flops of a two-entry buffer
`timescale 1ns/1ns
// Functional notes
// R1 - Buffer beats in a 2048-entry FIFO, holding at least one packet.
// R2 - FIFO is show-ahead: head word visible while the acknowledge is high.
// R3 - Raise ingress ready only when low and fill count at most 768.
// R4 - Accepted beat pulses write strobe, storing data, empty, first, last.
// R5 - Source starts packets with valid and sends beats gapless until last.
// R6 - Accepting a last beat drops ingress ready to recheck fill.
// R7 - With enough space, ingress ready rises again the next cycle.
// R8 - Start sending only with fill bits 10:2 nonzero and egress valid low.
// R9 - Each accepted egress beat pops the FIFO for the next beat.
// R10 - While egress ready is low, no pop and egress outputs hold; the code still pops while egress valid is low.
// R11 - After last egress beat is accepted, egress valid drops; recheck fill.
// R12 - MAC may stall at any beat; the adapter tolerates it.
// R13 - Source sends at most 8960 bytes, 1120 beats, per packet.
// R14 - Whole adapter runs synchronous to the single MAC stream clock.
// R15 - Reset empties the FIFO and holds ready, valid and strobes low.
module txpg_tx_packet_adapter (
  input  logic                          clk_i,
  input  logic                          sys_rst_i,
  input  logic                          ingress_valid_i,
  input  logic [txpg_pkg::DATA_W-1:0]   ingress_data_i,
  input  logic [txpg_pkg::IEMP_W-1:0]   ingress_empty_bytes_i,
  input  logic                          ingress_first_i,
  input  logic                          ingress_last_i,
  output logic                          ingress_ready_o,
  input  logic                          egress_ready_i,
  output logic                          egress_valid_o,
  output logic [txpg_pkg::DATA_W-1:0]   egress_data_o,
  output logic [txpg_pkg::EEMP_W-1:0]   egress_empty_bytes_o,
  output logic                          egress_first_o,
  output logic                          egress_last_o
);
  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [0:0] {
    EG_IDLE,
    EG_SEND
  } txpg_eg_state_t;

  typedef struct packed {
    logic                          ingress_ready;
    logic                          wr_strobe;
    logic [txpg_pkg::WORD_W-1:0]   wr_word;
    txpg_eg_state_t                eg_state;
  } txpg_st_t;

  txpg_st_t s_q, s_d;

  txpg_fifo_if fif ();

  logic                          accept;
  logic                          room_ok;
  logic                          start_ok;
  logic                          head_last;
  logic                          fifo_read_ack;
  logic                          skid_in_ready;
  logic [txpg_pkg::OUT_W-1:0]    skid_in_data;
  logic [txpg_pkg::OUT_W-1:0]    skid_out_data;
  logic                          skid_out_valid;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Packs one accepted source beat into a FIFO word
  function automatic logic [txpg_pkg::WORD_W-1:0] pack_word(
    input logic [txpg_pkg::DATA_W-1:0] data,
    input logic [txpg_pkg::IEMP_W-1:0] emp,
    input logic                        first,
    input logic                        last
  );
    logic [txpg_pkg::WORD_W-1:0] w;
    w = '0;
    w[txpg_pkg::F_DATA_LSB +: txpg_pkg::DATA_W] = data;
    w[txpg_pkg::F_EMP_LSB +: txpg_pkg::IEMP_W]  = emp;
    w[txpg_pkg::F_FIRST] = first;
    w[txpg_pkg::F_LAST]  = last;
    w[txpg_pkg::F_SPARE] = txpg_pkg::SPARE_VAL;
    return w;
  endfunction : pack_word

  // Widens the stored 2-bit empty count to the 3-bit stream field
  function automatic logic [txpg_pkg::OUT_W-1:0] unpack_word(
    input logic [txpg_pkg::WORD_W-1:0] w
  );
    logic [txpg_pkg::EEMP_W-1:0] emp;
    emp = {1'h0, w[txpg_pkg::F_EMP_LSB +: txpg_pkg::IEMP_W]};
    return {w[txpg_pkg::F_LAST], w[txpg_pkg::F_FIRST], emp,
            w[txpg_pkg::F_DATA_LSB +: txpg_pkg::DATA_W]};
  endfunction : unpack_word

  // ****************************************************************
  // Packet FIFO
  // ****************************************************************
  txpg_sa_fifo #(
    .DEPTH (txpg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .fif       (fif.store)
  );

  assign fif.wr_strobe = s_q.wr_strobe; // R4
  assign fif.wr_word   = s_q.wr_word;
  assign fif.rd_ack    = fifo_read_ack;

  // ****************************************************************
  // Write side
  // ****************************************************************
  assign accept  = ingress_valid_i && s_q.ingress_ready;
  // Count lags the registered write by one cycle; the slack is safe
  assign room_ok = (fif.fill_count <= txpg_pkg::FILL_LIMIT); // R3

  // ****************************************************************
  // Read side
  // ****************************************************************
  assign start_ok  = (fif.fill_count[txpg_pkg::START_MSB:txpg_pkg::START_LSB] != '0)
                     && !skid_out_valid; // R8
  assign head_last = fif.rd_word[txpg_pkg::F_LAST];
  // Pop only while the MAC takes beats or the output stage is empty
  assign fifo_read_ack = (s_q.eg_state == EG_SEND) && !fif.empty && skid_in_ready
                         && (egress_ready_i || !skid_out_valid); // R9 R10
  assign skid_in_data  = unpack_word(fif.rd_word);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.wr_strobe = accept; // R4
    if (accept) begin
      s_d.wr_word = pack_word(ingress_data_i, ingress_empty_bytes_i,
                              ingress_first_i, ingress_last_i);
    end
    if (!s_q.ingress_ready) begin
      s_d.ingress_ready = room_ok; // R3 R7
    end else if (accept && ingress_last_i) begin
      s_d.ingress_ready = 1'b0; // R6
    end
    case (s_q.eg_state)
      EG_IDLE: begin
        if (start_ok) s_d.eg_state = EG_SEND; // R8
      end
      EG_SEND: begin
        // Stop popping at the last beat so the next start is rechecked
        if (fifo_read_ack && head_last) s_d.eg_state = EG_IDLE; // R11
      end
      default: begin
        s_d.eg_state = EG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin // R14
    if (sys_rst_i) begin
      s_q <= '0; // R15
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  txpg_skid2 #(
    .W (txpg_pkg::OUT_W)
  ) u_out (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (fifo_read_ack),
    .in_data_i   (skid_in_data),
    .in_ready_o  (skid_in_ready),
    .out_valid_o (skid_out_valid),
    .out_data_o  (skid_out_data),
    .out_ready_i (egress_ready_i)
  );

  assign ingress_ready_o      = s_q.ingress_ready;
  assign egress_valid_o       = skid_out_valid;
  assign egress_data_o        = skid_out_data[txpg_pkg::DATA_W-1:0];
  assign egress_empty_bytes_o = skid_out_data[txpg_pkg::DATA_W +: txpg_pkg::EEMP_W];
  assign egress_first_o       = skid_out_data[txpg_pkg::OUT_W-2];
  assign egress_last_o        = skid_out_data[txpg_pkg::OUT_W-1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_ready_rise_room: assert property ( // R3
    $rose(s_q.ingress_ready) |-> $past(room_ok))
    else $error("ingress ready raised without room");

  a_write_pulse: assert property ( // R4
    accept |=> (fif.wr_strobe && fif.wr_word[txpg_pkg::F_LAST] == $past(ingress_last_i)
               && fif.wr_word[txpg_pkg::F_DATA_LSB +: txpg_pkg::DATA_W]
                  == $past(ingress_data_i)))
    else $error("accepted beat not written");

  a_no_spurious_wr: assert property ( // R4
    !accept |=> !fif.wr_strobe)
    else $error("write strobe without accepted beat");

  a_last_closes: assert property ( // R6
    (accept && ingress_last_i) |=> !ingress_ready_o)
    else $error("ingress ready stayed high after last beat");

  a_reopen_next: assert property ( // R7
    (!ingress_ready_o && room_ok) |=> ingress_ready_o)
    else $error("ingress ready not re-raised with room");

  a_gated_start: assert property ( // R8
    ($rose(s_q.eg_state == EG_SEND)) |-> $past(start_ok))
    else $error("packet started without data or while valid");

  a_pop_on_take: assert property ( // R9
    (egress_valid_o && egress_ready_i && !egress_last_o && s_q.eg_state == EG_SEND
     && !fif.empty) |-> fifo_read_ack)
    else $error("no pop while MAC takes a beat");

  a_stall_no_pop: assert property ( // R10
    (egress_valid_o && !egress_ready_i) |-> !fifo_read_ack)
    else $error("FIFO popped during MAC stall");

  a_valid_drop: assert property ( // R11
    (egress_valid_o && egress_ready_i && egress_last_o) |=> !egress_valid_o)
    else $error("egress valid held after last beat");

  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0) // R15
    sys_rst_i |=> (!ingress_ready_o && !egress_valid_o && !fif.wr_strobe
                   && !fifo_read_ack && fif.empty))
    else $error("outputs active after reset");

  c_packet_start: cover property ($rose(s_q.eg_state == EG_SEND));
  c_mid_stall: cover property (
    egress_valid_o && !egress_ready_i && !egress_last_o ##1 egress_ready_i);
  c_reopen: cover property (accept && ingress_last_i ##1 !ingress_ready_o ##1 ingress_ready_o);
  c_last_out: cover property (egress_valid_o && egress_ready_i && egress_last_o);
  c_full_hold: cover property (!ingress_ready_o && !room_ok);

  // ****************************************************************
  // Flow and field checks
  // ****************************************************************
  a_pop_not_empty: assert property ( // R9
    fifo_read_ack |-> !fif.empty)
    else $error("pop from empty buffer");

  a_idle_no_pop: assert property ( // R11
    (s_q.eg_state == EG_IDLE) |-> !fifo_read_ack)
    else $error("pop between packets");

  a_stop_at_last: assert property ( // R11
    (fifo_read_ack && head_last) |=> (s_q.eg_state == EG_IDLE))
    else $error("reading went on past last beat");

  a_start_when_idle: assert property ( // R8
    (s_q.eg_state == EG_IDLE && start_ok) |=> (s_q.eg_state == EG_SEND))
    else $error("start not taken with data ready");

  // Holds only while packets stay within the length limit
  a_no_overfill: assert property ( // R1
    fif.wr_strobe |-> (fif.fill_count < txpg_pkg::CNT_W'(txpg_pkg::FIFO_DEPTH)))
    else $error("write into full buffer");

  a_empty_top_zero: assert property ( // R8
    egress_valid_o |-> !egress_empty_bytes_o[txpg_pkg::EEMP_W-1])
    else $error("empty count above stored range");

  // Underrun needs a source gap, so a rising valid opens a packet
  a_first_opens: assert property ( // R8
    $rose(egress_valid_o) |-> egress_first_o)
    else $error("packet opened without first flag");

  a_ready_holds: assert property ( // R6
    (ingress_ready_o && !(accept && ingress_last_i)) |=> ingress_ready_o)
    else $error("ingress ready dropped inside a packet");

  a_refused_not_stored: assert property ( // R3
    !ingress_ready_o |=> !fif.wr_strobe)
    else $error("beat stored while ready low");

  a_write_fields: assert property ( // R4
    accept |=> (fif.wr_word[txpg_pkg::F_FIRST] == $past(ingress_first_i)
               && fif.wr_word[txpg_pkg::F_EMP_LSB +: txpg_pkg::IEMP_W]
                  == $past(ingress_empty_bytes_i)))
    else $error("first flag or empty count not written");

  a_spare_zero: assert property ( // R4
    fif.wr_strobe |-> (fif.wr_word[txpg_pkg::F_SPARE] == txpg_pkg::SPARE_VAL))
    else $error("spare bit set in buffer word");

  a_flags_hold: assert property ( // R10
    (egress_valid_o && !egress_ready_i) |=> (egress_valid_o && $stable(egress_first_o)
     && $stable(egress_last_o) && $stable(egress_empty_bytes_o)))
    else $error("egress flags changed during stall");

endmodule : txpg_tx_packet_adapter

// *** tb/txpg_mac_model.sv ***
// Purpose: MAC transmit stream sink with selectable stall pattern
// Assumes: Same clock as the adapter; ready is driven from a flop
// Notes:   mode_i 0 always ready, 1 stalls every other cycle, 2 never ready
`timescale 1ns/1ns
module txpg_mac_model (
  input  logic                          clk_i,
  input  logic                          sys_rst_i,
  input  logic [1:0]                    mode_i,
  input  logic                          egress_valid_i,
  input  logic [txpg_pkg::DATA_W-1:0]   egress_data_i,
  input  logic [txpg_pkg::EEMP_W-1:0]   egress_empty_bytes_i,
  input  logic                          egress_first_i,
  input  logic                          egress_last_i,
  output logic                          egress_ready_o
);
  logic [txpg_pkg::OUT_W-1:0] beat;
  logic [txpg_pkg::OUT_W-1:0] beat_q;
  logic                       vld_q;
  logic                       rdy_q;
  logic                       last_q;
  logic                       tog_q;
  logic [txpg_pkg::OUT_W-1:0] rx_q [$];
  int                         hold_err = 0;
  int                         gap_err = 0;

  assign beat = {egress_last_i, egress_first_i, egress_empty_bytes_i, egress_data_i};

  // ****************************************************************
  // Sink and protocol watch
  // ****************************************************************
  // Plain always: the bench pops and clears the capture queue
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      egress_ready_o <= 1'b0;
      tog_q          <= 1'b0;
      vld_q          <= 1'b0;
      rdy_q          <= 1'b0;
      last_q         <= 1'b0;
      // Error counts survive a mid-run reset
    end else begin
      tog_q          <= ~tog_q;
      // Stalls land at any beat, mid-packet included
      egress_ready_o <= (mode_i == 2'h0) | ((mode_i == 2'h1) & tog_q);
      if (egress_valid_i && egress_ready_o)
        rx_q.push_back(beat);
      if (vld_q && !rdy_q && (egress_valid_i !== 1'b1 || beat !== beat_q))
        hold_err <= hold_err + 1;
      if (last_q && egress_valid_i !== 1'b0)
        gap_err <= gap_err + 1;
      vld_q  <= egress_valid_i;
      rdy_q  <= egress_ready_o;
      beat_q <= beat;
      last_q <= egress_valid_i & egress_ready_o & egress_last_i;
    end
  end
endmodule : txpg_mac_model

// *** tb/txpg_tx_packet_adapter_tb.sv ***
// Purpose: Self-checking bench for the transmit packet adapter
// Assumes: Bench plays the offload engine; a model plays the MAC
// Notes:   Outputs are read just after the edge, so they show pre-edge values
`timescale 1ns/1ns
module txpg_tx_packet_adapter_tb;
  logic                          clk_i;
  logic                          sys_rst_i;
  logic                          ingress_valid_i;
  logic [txpg_pkg::DATA_W-1:0]   ingress_data_i;
  logic [txpg_pkg::IEMP_W-1:0]   ingress_empty_bytes_i;
  logic                          ingress_first_i;
  logic                          ingress_last_i;
  logic                          ingress_ready_o;
  logic                          egress_ready_i;
  logic                          egress_valid_o;
  logic [txpg_pkg::DATA_W-1:0]   egress_data_o;
  logic [txpg_pkg::EEMP_W-1:0]   egress_empty_bytes_o;
  logic                          egress_first_o;
  logic                          egress_last_o;
  logic [1:0]                    mode;
  logic [txpg_pkg::OUT_W-1:0]    exp_q [$];
  int                            n_fail;
  int                            comparisons;
  int                            cycles = 0;

  txpg_tx_packet_adapter dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ingress_valid_i(ingress_valid_i),
    .ingress_data_i(ingress_data_i), .ingress_empty_bytes_i(ingress_empty_bytes_i),
    .ingress_first_i(ingress_first_i), .ingress_last_i(ingress_last_i),
    .ingress_ready_o(ingress_ready_o), .egress_ready_i(egress_ready_i),
    .egress_valid_o(egress_valid_o), .egress_data_o(egress_data_o),
    .egress_empty_bytes_o(egress_empty_bytes_o), .egress_first_o(egress_first_o),
    .egress_last_o(egress_last_o));

  txpg_mac_model mac_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode),
    .egress_valid_i(egress_valid_o), .egress_data_i(egress_data_o),
    .egress_empty_bytes_i(egress_empty_bytes_o), .egress_first_i(egress_first_o),
    .egress_last_i(egress_last_o), .egress_ready_o(egress_ready_i));

  // ****************************************************************
  // Compare and report
  // ****************************************************************
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_beat(input logic [txpg_pkg::OUT_W-1:0] got,
                            input logic [txpg_pkg::OUT_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_beat

  task automatic check_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_cnt

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Source and drain helpers
  // ****************************************************************
  // Beats go out gapless; a refused beat is held until taken
  task automatic send_pkt(input int n, input logic [63:0] base, input logic [1:0] emp,
                          input logic rerise);
    int i;
    int t;
    i = 0;
    t = 0;
    while (i < n && t < 5000) begin
      ingress_valid_i       <= 1'b1;
      ingress_data_i        <= base + 64'(i);
      ingress_empty_bytes_i <= emp;
      ingress_first_i       <= (i == 0);
      ingress_last_i        <= (i == n - 1);
      @(posedge clk_i);
      t++;
      if (ingress_ready_o === 1'b1) begin
        exp_q.push_back({(i == n - 1), (i == 0), 1'b0, emp, base + 64'(i)});
        i++;
      end
    end
    check_cnt(i, n);
    ingress_valid_i <= 1'b0;
    @(posedge clk_i);
    check_bit(ingress_ready_o, 1'b0);
    @(posedge clk_i);
    check_bit(ingress_ready_o, rerise);
  endtask : send_pkt

  task automatic drain(input int limit);
    int t;
    t = 0;
    while (mac_u.rx_q.size() < exp_q.size() && t < limit) begin
      @(posedge clk_i);
      t++;
    end
    repeat (4) @(posedge clk_i);
    check_cnt(mac_u.rx_q.size(), exp_q.size());
    while (exp_q.size() > 0 && mac_u.rx_q.size() > 0)
      check_beat(mac_u.rx_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    mac_u.rx_q.delete();
  endtask : drain

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    repeat (12) @(posedge clk_i);
    check_bit(ingress_ready_o, 1'b0);
    check_bit(egress_valid_o, 1'b0);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    check_bit(ingress_ready_o, 1'b0);
    @(posedge clk_i);
    check_bit(ingress_ready_o, 1'b1);
  endtask : t_reset

  task automatic t_basic();
    send_pkt(4, 64'h1000, 2'h3, 1'b1);
    drain(200);
  endtask : t_basic

  task automatic t_stalled_burst();
    mode <= 2'h1;
    send_pkt(6, 64'ha000, 2'h0, 1'b1);
    send_pkt(5, 64'hb000, 2'h1, 1'b1);
    send_pkt(8, 64'hc000, 2'h2, 1'b1);
    drain(500);
  endtask : t_stalled_burst

  // A packet under four words waits for more data behind it
  task automatic t_short_wait();
    mode <= 2'h0;
    send_pkt(2, 64'hd000, 2'h3, 1'b1);
    repeat (30) @(posedge clk_i);
    check_cnt(mac_u.rx_q.size(), 0);
    check_bit(egress_valid_o, 1'b0);
    send_pkt(4, 64'he000, 2'h1, 1'b1);
    drain(500);
  endtask : t_short_wait

  task automatic t_full_packet();
    mode <= 2'h2;
    send_pkt(1120, 64'h10000, 2'h2, 1'b0);
    repeat (40) begin
      @(posedge clk_i);
      check_bit(ingress_ready_o, 1'b0);
    end
    check_bit(egress_valid_o, 1'b1);
    mode <= 2'h1;
    for (int t = 0; t < 3000 && ingress_ready_o !== 1'b1; t++)
      @(posedge clk_i);
    check_bit(ingress_ready_o, 1'b1);
    drain(5000);
  endtask : t_full_packet

  // Reset mid-run must throw away what the buffer holds
  task automatic t_mid_reset();
    mode <= 2'h0;
    send_pkt(2, 64'hf000, 2'h0, 1'b1);
    exp_q.delete();
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check_bit(ingress_ready_o, 1'b0);
    check_bit(egress_valid_o, 1'b0);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    send_pkt(4, 64'h2000, 2'h3, 1'b1);
    drain(500);
  endtask : t_mid_reset

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    sys_rst_i             = 1'b1;
    ingress_valid_i       = 1'b0;
    ingress_data_i        = 64'h0;
    ingress_empty_bytes_i = 2'h0;
    ingress_first_i       = 1'b0;
    ingress_last_i        = 1'b0;
    mode                  = 2'h0;
    n_fail                = 0;
    comparisons           = 0;
    t_reset();
    t_basic();
    t_stalled_burst();
    t_short_wait();
    t_full_packet();
    t_mid_reset();
    check_cnt(mac_u.hold_err, 0);
    check_cnt(mac_u.gap_err, 0);
    finish_test();
  end
endmodule : txpg_tx_packet_adapter_tb
